// ---- rtl/ifrc_pkg.sv ----
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`default_nettype none
package ifrc_pkg;

  // --------------------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------------------
  localparam int unsigned DATA_W = 32;
  localparam logic [7:0] IDX_CFG3 = 8'h22;
  localparam logic [7:0] IDX_LINE_STD = 8'h34;
  localparam logic [1:0] WORD_LSBS = 2'h0;
  localparam logic [7:0] CFG3_RST = 8'h00;
  localparam logic [7:0] LINE_STD_RST = 8'h00;
  localparam int unsigned LINE_STD_BIT = 2;

  // --------------------------------------------------------------------------
  // Field layout, bit 7 down to bit 0
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic prog_div;
    logic lock_at_eight_khz;
    logic [1:0] activity_bucket_select;
    logic [3:0] freq_code;
  } ifrc_cfg_t;

  // --------------------------------------------------------------------------
  // Frequency codes and their nominal rates in kHz
  // --------------------------------------------------------------------------
  localparam int unsigned KHZ_W = 18;
  localparam logic [3:0] FC_8K = 4'h0;
  localparam logic [3:0] FC_T1E1 = 4'h1;
  localparam logic [3:0] FC_6M48 = 4'h2;
  localparam logic [3:0] FC_19M44 = 4'h3;
  localparam logic [3:0] FC_25M92 = 4'h4;
  localparam logic [3:0] FC_38M88 = 4'h5;
  localparam logic [3:0] FC_50M = 4'h6;
  localparam logic [3:0] FC_77M76 = 4'h7;
  localparam logic [3:0] FC_155M52 = 4'h8;
  localparam logic [3:0] FC_2K = 4'h9;
  localparam logic [3:0] FC_4K = 4'hA;
  localparam logic [KHZ_W-1:0] KHZ_8 = 18'h00008;
  localparam logic [KHZ_W-1:0] KHZ_1544 = 18'h00608;
  localparam logic [KHZ_W-1:0] KHZ_2048 = 18'h00800;
  localparam logic [KHZ_W-1:0] KHZ_6480 = 18'h01950;
  localparam logic [KHZ_W-1:0] KHZ_19440 = 18'h04BF0;
  localparam logic [KHZ_W-1:0] KHZ_25920 = 18'h06540;
  localparam logic [KHZ_W-1:0] KHZ_38880 = 18'h097E0;
  localparam logic [KHZ_W-1:0] KHZ_50000 = 18'h0C350;
  localparam logic [KHZ_W-1:0] KHZ_77760 = 18'h12FC0;
  localparam logic [KHZ_W-1:0] KHZ_155520 = 18'h25F80;
  localparam logic [KHZ_W-1:0] KHZ_2 = 18'h00002;
  localparam logic [KHZ_W-1:0] KHZ_4 = 18'h00004;
  localparam logic [KHZ_W-1:0] KHZ_NONE = 18'h00000;

  typedef struct packed {
    logic known;
    logic [KHZ_W-1:0] khz;
  } ifrc_freq_t;

endpackage : ifrc_pkg
`default_nettype wire

// ---- rtl/ifrc_ref_mux.sv ----
`timescale 1ns/10ps
`default_nettype none
module ifrc_ref_mux
  import ifrc_pkg::*;
#(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Select and candidates
  input wire logic sel,
  input wire logic [W-1:0] a,
  input wire logic [W-1:0] b,
  // Registered choice
  output logic [W-1:0] y
);

  logic [W-1:0] y_r;
  logic [W-1:0] y_nxt;

  // --------------------------------------------------------------------------
  // Pick a or b, register to keep glitches off the reference path
  // --------------------------------------------------------------------------
  always_comb begin
    y_nxt = sel ? b : a;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      y_r <= '0;
    end else begin
      y_r <= y_nxt;
    end
  end

  assign y = y_r;

endmodule : ifrc_ref_mux
`default_nettype wire

// ---- rtl/ifrc_freq_decode.sv ----
`timescale 1ns/10ps
`default_nettype none
module ifrc_freq_decode
  import ifrc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Code and line standard
  input wire logic [3:0] freq_code,
  input wire logic line_standard_select,
  // Registered nominal rate
  output ifrc_freq_t freq
);

  ifrc_freq_t freq_r;
  ifrc_freq_t freq_nxt;

  // --------------------------------------------------------------------------
  // Code to nominal rate; unused codes report not known
  // --------------------------------------------------------------------------
  always_comb begin
    freq_nxt.known = 1'b1;
    case (freq_code)
      FC_8K: freq_nxt.khz = KHZ_8;
      FC_T1E1: freq_nxt.khz = line_standard_select ? KHZ_1544 : KHZ_2048;
      FC_6M48: freq_nxt.khz = KHZ_6480;
      FC_19M44: freq_nxt.khz = KHZ_19440;
      FC_25M92: freq_nxt.khz = KHZ_25920;
      FC_38M88: freq_nxt.khz = KHZ_38880;
      FC_50M: freq_nxt.khz = KHZ_50000;
      FC_77M76: freq_nxt.khz = KHZ_77760;
      FC_155M52: freq_nxt.khz = KHZ_155520;
      FC_2K: freq_nxt.khz = KHZ_2;
      FC_4K: freq_nxt.khz = KHZ_4;
      default: begin
        freq_nxt.khz = KHZ_NONE;
        freq_nxt.known = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_r <= '0;
    end else begin
      freq_r <= freq_nxt;
    end
  end

  assign freq = freq_r;

endmodule : ifrc_freq_decode
`default_nettype wire

// ---- rtl/ifrc_top.sv ----
// Chosen here: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module ifrc_top
  import ifrc_pkg::*;
#(
  parameter int unsigned ADDR_W = 12
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,

  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [DATA_W-1:0] prdata,
  output logic pslverr,

  // Reference candidates for input 3
  input wire logic ref_in,
  input wire logic prog_div_in,
  input wire logic preset_div_in,

  // Routed references
  output logic dpll_ref,
  output logic monitor_ref,

  // Configuration seen by the rest of the device
  output ifrc_cfg_t cfg,
  output logic [1:0] activity_bucket_select,
  output logic line_standard_select,
  output ifrc_freq_t nominal_freq
);

  // --------------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------------
  if (ADDR_W < 10) begin : g_addr_chk
    $error("ADDR_W too narrow for the register map");
  end

  // --------------------------------------------------------------------------
  // Byte addresses, four per index
  // --------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CFG3 =
    ADDR_W'({IDX_CFG3, WORD_LSBS});
  localparam logic [ADDR_W-1:0] ADDR_LINE_STD =
    ADDR_W'({IDX_LINE_STD, WORD_LSBS});

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  ifrc_cfg_t cfg_r;
  ifrc_cfg_t cfg_nxt;
  logic line_std_r;
  logic line_std_nxt;
  logic [DATA_W-1:0] prdata_r;
  logic [DATA_W-1:0] prdata_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic setup_ph;
  logic access_ph;
  logic hit_cfg;
  logic hit_line;
  logic mapped;
  logic wr_low;
  logic dpll_pre;

  // --------------------------------------------------------------------------
  // Bus phase and decode
  // --------------------------------------------------------------------------
  // Zero wait states: read data is fetched at setup, so access always ends
  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign pready = access_ph;
  assign hit_cfg = (paddr == ADDR_CFG3);
  assign hit_line = (paddr == ADDR_LINE_STD);
  assign mapped = hit_cfg || hit_line;
  // Only byte lane 0 holds register bits
  assign wr_low = access_ph && pwrite && pstrb[0];

  // --------------------------------------------------------------------------
  // Register file next state
  // --------------------------------------------------------------------------
  always_comb begin
    cfg_nxt = cfg_r;
    line_std_nxt = line_std_r;
    if (wr_low && hit_cfg) begin
      cfg_nxt = ifrc_cfg_t'(pwdata[7:0]);
    end
    if (wr_low && hit_line) begin
      line_std_nxt = pwdata[LINE_STD_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= ifrc_cfg_t'(CFG3_RST);
      line_std_r <= LINE_STD_RST[LINE_STD_BIT];
    end else begin
      cfg_r <= cfg_nxt;
      line_std_r <= line_std_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Read data and error, captured in the setup cycle
  // --------------------------------------------------------------------------
  // Held through access so prdata comes straight from flip-flops
  always_comb begin
    prdata_nxt = prdata_r;
    pslverr_nxt = pslverr_r;
    if (setup_ph) begin
      prdata_nxt = '0;
      pslverr_nxt = !mapped;
      if (!pwrite && hit_cfg) begin
        prdata_nxt[7:0] = cfg_r;
      end
      if (!pwrite && hit_line) begin
        prdata_nxt[LINE_STD_BIT] = line_std_r;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata = prdata_r;
  // Error shown only while the transfer completes
  assign pslverr = pslverr_r && access_ph;

  // --------------------------------------------------------------------------
  // Reference routing
  // --------------------------------------------------------------------------
  // Monitor sees the programmable divider or the raw input
  ifrc_ref_mux #(
    .W(1)
  ) u_mon_mux (
    .pclk(pclk),
    .presetn(presetn),
    .sel(cfg_r.prog_div),
    .a(ref_in),
    .b(prog_div_in),
    .y(monitor_ref)
  );

  // PLL path: preset divider overrides, so an 8 kHz lock wins
  assign dpll_pre = cfg_r.prog_div ? prog_div_in : ref_in;

  ifrc_ref_mux #(
    .W(1)
  ) u_dpll_mux (
    .pclk(pclk),
    .presetn(presetn),
    .sel(cfg_r.lock_at_eight_khz),
    .a(dpll_pre),
    .b(preset_div_in),
    .y(dpll_ref)
  );

  // --------------------------------------------------------------------------
  // Frequency decode
  // --------------------------------------------------------------------------
  ifrc_freq_decode u_freq (
    .pclk(pclk),
    .presetn(presetn),
    .freq_code(cfg_r.freq_code),
    .line_standard_select(line_std_r),
    .freq(nominal_freq)
  );

  // --------------------------------------------------------------------------
  // Configuration outputs, straight from the register
  // --------------------------------------------------------------------------
  assign cfg = cfg_r;
  assign activity_bucket_select = cfg_r.activity_bucket_select;
  assign line_standard_select = line_std_r;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  sequence s_wr_cfg;
    psel && penable && pwrite && pstrb[0] && (paddr == ADDR_CFG3);
  endsequence

  sequence s_rd_cfg_setup;
    psel && !penable && !pwrite && (paddr == ADDR_CFG3);
  endsequence

  a_cfg_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
    s_wr_cfg |=> (cfg_r == $past(pwdata[7:0])))
    else $error("config write not stored");

  a_cfg_read_back: assert property (@(posedge pclk) disable iff (!presetn)
    s_rd_cfg_setup ##1 (psel && penable) |->
      (prdata == {24'h000000, $past(cfg_r)}) && !pslverr)
    else $error("config read data wrong");

  // Route checks skip the edge that still saw reset, where the muxes load zero
  a_mon_prog_route: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 ($past(presetn) && $past(cfg_r.prog_div)) |-> (monitor_ref == $past(prog_div_in)))
    else $error("monitor not on programmable divider");

  a_mon_raw_route: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 ($past(presetn) && !$past(cfg_r.prog_div)) |-> (monitor_ref == $past(ref_in)))
    else $error("monitor not on raw input");

  a_dpll_preset: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 ($past(presetn) && $past(cfg_r.lock_at_eight_khz)) |->
      (dpll_ref == $past(preset_div_in)))
    else $error("pll not on preset divider");

  a_dpll_direct_route: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 ($past(presetn) && !$past(cfg_r.lock_at_eight_khz)) |-> (dpll_ref == $past(dpll_pre)))
    else $error("pll not on direct path");

  a_strb_drop: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pwrite && !pstrb[0]) |=> $stable(cfg_r))
    else $error("write without low strobe changed config");

  a_line_std_write: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pwrite && pstrb[0] && hit_line) |=>
      (line_std_r == $past(pwdata[LINE_STD_BIT])))
    else $error("line standard write not stored");

  a_bucket_follows: assert property (@(posedge pclk) disable iff (!presetn)
    s_wr_cfg |=> (activity_bucket_select == $past(pwdata[5:4])))
    else $error("bucket select not updated");

  a_freq_eight: assert property (@(posedge pclk) disable iff (!presetn)
    presetn && (cfg_r.freq_code == FC_8K) |=> (nominal_freq.khz == KHZ_8) && nominal_freq.known)
    else $error("code zero not 8 kHz");

  a_freq_line_std: assert property (@(posedge pclk) disable iff (!presetn)
    presetn && (cfg_r.freq_code == FC_T1E1) |=>
      (nominal_freq.khz == ($past(line_std_r) ? KHZ_1544 : KHZ_2048)))
    else $error("code one rate wrong for line standard");

  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !mapped) ##1 (psel && penable) |-> pslverr && pready)
    else $error("unmapped access without error");

endmodule : ifrc_top
`default_nettype wire

// ---- bench/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import ifrc_pkg::*;
  // --------------------------------------------------------------------------
  // Signals and expectations
  // --------------------------------------------------------------------------
  typedef struct packed {logic wr; logic err; logic [31:0] d;} ifrc_exp_t;
  localparam logic [11:0] A_CFG = {2'h0, IDX_CFG3, WORD_LSBS};
  localparam logic [11:0] A_LS = {2'h0, IDX_LINE_STD, WORD_LSBS};
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, ref_in = 1'b0, prog_div_in = 1'b0, preset_div_in = 1'b0;
  logic dpll_ref, monitor_ref, line_standard_select, x_dpll, x_mon;
  logic [1:0] activity_bucket_select;
  ifrc_cfg_t cfg;
  ifrc_freq_t nominal_freq, x_freq;
  logic [7:0] sh_cfg = 8'h00;
  logic sh_ls = 1'b0, chk_v = 1'b0;
  int n_mismatch = 0, compares = 0, cycles = 0;
  integer seed = 32'h93B6;
  ifrc_exp_t q[$];
  ifrc_exp_t e;

  // 200 MHz clock
  always #2.5 pclk = ~pclk;

  ifrc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .ref_in(ref_in), .prog_div_in(prog_div_in),
    .preset_div_in(preset_div_in), .dpll_ref(dpll_ref), .monitor_ref(monitor_ref),
    .cfg(cfg), .activity_bucket_select(activity_bucket_select),
    .line_standard_select(line_standard_select), .nominal_freq(nominal_freq));

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  // Nominal rate per code; unused codes are unknown
  function automatic ifrc_freq_t exp_freq(input logic [3:0] c, input logic ls);
    logic [KHZ_W-1:0] k;
    case (c)
      FC_8K: k = KHZ_8;
      FC_T1E1: k = ls ? KHZ_1544 : KHZ_2048;
      FC_6M48: k = KHZ_6480;
      FC_19M44: k = KHZ_19440;
      FC_25M92: k = KHZ_25920;
      FC_38M88: k = KHZ_38880;
      FC_50M: k = KHZ_50000;
      FC_77M76: k = KHZ_77760;
      FC_155M52: k = KHZ_155520;
      FC_2K: k = KHZ_2;
      FC_4K: k = KHZ_4;
      default: k = KHZ_NONE;
    endcase
    return {c <= FC_4K, k};
  endfunction : exp_freq

  // One APB transfer, left held so a next setup may follow at once
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    ifrc_exp_t x;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    // Expect what the register holds at the setup edge
    x.wr = wr;
    x.err = (a != A_CFG) && (a != A_LS);
    x.d = (a == A_CFG) ? {24'h0, sh_cfg} : (a == A_LS) ? {29'h0, sh_ls, 2'h0} : 32'h0;
    q.push_back(x);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    if (wr && s[0] && a == A_CFG) sh_cfg <= d[7:0];
    if (wr && s[0] && a == A_LS) sh_ls <= d[2];
  endtask : apb

  task automatic idle(input int n);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (n) @(posedge pclk);
  endtask : idle

  // --------------------------------------------------------------------------
  // Output watcher and random reference stimulus
  // --------------------------------------------------------------------------
  // Routing and rate are predicted one edge ahead, since both outputs are registered
  always @(posedge pclk) begin
    cycles++;
    if (cycles > 3000) begin
      n_mismatch++;
      report_and_stop();
    end
    {ref_in, prog_div_in, preset_div_in} <= 3'($random(seed));
    if (presetn && psel && penable && pready) begin
      e = q.pop_front();
      check(pslverr, e.err);
      if (!e.wr) check(prdata, e.d);
    end
    if (chk_v && presetn) begin
      check(monitor_ref, x_mon);
      check(dpll_ref, x_dpll);
      check(nominal_freq, x_freq);
    end
    if (presetn) begin
      check(cfg, sh_cfg);
      check(activity_bucket_select, sh_cfg[5:4]);
      check(line_standard_select, sh_ls);
    end
    chk_v <= presetn;
    x_mon <= sh_cfg[7] ? prog_div_in : ref_in;
    x_dpll <= sh_cfg[6] ? preset_div_in : (sh_cfg[7] ? prog_div_in : ref_in);
    x_freq <= exp_freq(sh_cfg[3:0], sh_ls);
  end

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    logic [31:0] d;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, A_CFG, 32'h0, 4'hF);
    apb(1'b0, A_LS, 32'h0, 4'hF);
    idle(2);
    $display("test reset_values done");
    // All codes and all routing/bucket patterns, back to back with read-back
    for (int i = 0; i < 16; i++) begin
      d = $random(seed);
      d[7:0] = {4'(i) + 4'h5, 4'(i)};
      apb(1'b1, A_CFG, d, 4'hF);
      apb(1'b0, A_CFG, 32'h0, 4'hF);
      idle(3);
    end
    $display("test codes_and_routing done");
    // Line standard picks the rate of code 0001; upper bits of its word read zero
    for (int ls = 1; ls >= 0; ls--) begin
      d = $random(seed);
      d[2] = ls[0];
      apb(1'b1, A_LS, d, 4'hF);
      apb(1'b1, A_CFG, 32'h0000_0001, 4'hF);
      apb(1'b0, A_LS, 32'h0, 4'hF);
      idle(3);
    end
    $display("test line_standard done");
    // Writes without the low byte strobe and to an unmapped word are dropped
    apb(1'b1, A_CFG, 32'h0000_00C6, 4'hE);
    apb(1'b1, A_CFG + 12'h004, 32'h0000_00FF, 4'hF);
    apb(1'b0, A_CFG + 12'h004, 32'h0, 4'hF);
    apb(1'b0, A_CFG, 32'h0, 4'hF);
    idle(3);
    $display("test refused_writes done");
    // Reset in mid-run clears both registers
    apb(1'b1, A_CFG, 32'h0000_00F5, 4'hF);
    idle(2);
    presetn <= 1'b0;
    sh_cfg <= 8'h00;
    sh_ls <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, A_CFG, 32'h0, 4'hF);
    apb(1'b0, A_LS, 32'h0, 4'hF);
    idle(3);
    $display("test mid_reset done");
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
